// ---- hw/amp_fault_pkg.sv ----
// constants, register map and carrier types for the fault/clip register slice
`default_nettype none
package amp_fault_pkg;
   ////////////////////////////////////////////////////////////////////////
   localparam logic [7:0] REG_RSVD_A = 8'h07;
   localparam logic [7:0] REG_FAULT = 8'h08;
   localparam logic [7:0] REG_RSVD_LO = 8'h09;
   localparam logic [7:0] REG_RSVD_HI = 8'h0f;
   localparam logic [7:0] REG_CLIP_MID = 8'h10;
   localparam logic [7:0] REG_CLIP_LOW = 8'h11;

   localparam int RSVD_MSB = 7;
   localparam int RSVD_LSB = 6;
   localparam int OC_SEL_MSB = 5;
   localparam int OC_SEL_LSB = 4;
   localparam int CLK_FLAG_BIT = 3;
   localparam int OC_FLAG_BIT = 2;
   localparam int DC_FLAG_BIT = 1;
   localparam int OT_FLAG_BIT = 0;
   localparam int CLIP_LOW_MSB = 7;
   localparam int CLIP_LOW_LSB = 2;

   localparam logic [1:0] THR_SEL_RESET = 2'h0;
   localparam logic [7:0] CLIP_MID_RESET = 8'hff;
   localparam logic [7:0] CLIP_LOW_RESET = 8'hfc;
   localparam logic [1:0] THR_100 = 2'h0;
   localparam logic [1:0] THR_75 = 2'h1;
   localparam logic [1:0] THR_50 = 2'h2;
   localparam logic [1:0] THR_25 = 2'h3;

   localparam int CLIP_W = 20;
   localparam int UPPER_W = 6;
   localparam int SAMPLE_W = 24;
   localparam int CUR_W = 12;
   localparam logic [3:0] BYTE_BITS = 4'h8;

   ////////////////////////////////////////////////////////////////////////
   typedef enum logic [6:0] {
      BUS_IDLE = 7'h01,
      BUS_ADDR = 7'h02,
      BUS_AACK = 7'h04,
      BUS_WDATA = 7'h08,
      BUS_WACK = 7'h10,
      BUS_RDATA = 7'h20,
      BUS_RACK = 7'h40
   } bus_state_type;

   typedef struct packed {
      logic signed [SAMPLE_W-1:0] left;
      logic signed [SAMPLE_W-1:0] right;
   } stereo_sample_type;

   typedef struct packed {
      logic scl_s1;
      logic scl_s2;
      logic scl_d;
      logic sda_s1;
      logic sda_s2;
      logic sda_d;
      logic sd_s1;
      logic sd_s2;
      bus_state_type bus_state;
      logic [3:0] bit_cnt;
      logic [7:0] shift;
      logic rw;
      logic first;
      logic [7:0] ptr;
      logic sda_oe;
      logic sda_out;
      logic [1:0] thr_sel;
      logic clk_flag;
      logic oc_flag;
      logic dc_flag;
      logic ot_flag;
      logic [7:0] clip_mid;
      logic [7:0] clip_low;
      logic amp_run;
      logic out_valid;
      stereo_sample_type out;
   } state_type;

   localparam state_type STATE_RESET = '{
      scl_s1: 1'b1, scl_s2: 1'b1, scl_d: 1'b1,
      sda_s1: 1'b1, sda_s2: 1'b1, sda_d: 1'b1,
      sd_s1: 1'b0, sd_s2: 1'b0,
      bus_state: BUS_IDLE,
      bit_cnt: 4'h0, shift: 8'h00, rw: 1'b0, first: 1'b0, ptr: 8'h00,
      sda_oe: 1'b0, sda_out: 1'b0,
      thr_sel: THR_SEL_RESET,
      clk_flag: 1'b0, oc_flag: 1'b0, dc_flag: 1'b0, ot_flag: 1'b0,
      clip_mid: CLIP_MID_RESET, clip_low: CLIP_LOW_RESET,
      amp_run: 1'b0, out_valid: 1'b0,
      out: '{left: 24'h000000, right: 24'h000000}
   };
endpackage
`default_nettype wire

// ---- hw/amp_fault_status_clip_regs.sv ----
// fault status and clip threshold registers behind a two-wire control port
// Operation
// - overcurrent select bits 5:4 reset 00; 01/10/11 give 75/50/25 percent
// - clock fault flag bit 3 follows the clock error, never latches
// - overcurrent flag bit 2 latches, halts amplifier until shutdown toggled
// - dc offset flag bit 1 latches, halts amplifier until shutdown toggled
// - overtemp flag bit 0 latches, halts amplifier until shutdown toggled
// - fault register bits 7:6 read zero and cannot be written
// - register 0x10 supplies clip threshold bits 13:6
// - register 0x11 bits 7:2 supply clip threshold bits 5:0
// - shutdown by pin low or control bit low clears latched faults
`default_nettype none
module amp_fault_status_clip_regs #(
   parameter logic [6:0] DEV_ADDR = 7'h6c,
   parameter logic [11:0] OC_NOMINAL = 12'h800
) (
   input wire logic clk, // 125 MHz system clock
   input wire logic rst_b, // async reset, active low
   input wire logic scl_in, // control port clock pin
   input wire logic sda_in, // control port data pin level
   output logic sda_out, // data pin drive value, always low
   output logic sda_oe, // data pin pull-down enable
   input wire logic amp_shutdown_n, // shutdown pin, low = shutdown
   input wire logic sw_shutdown_n, // shutdown control bit, low = shutdown
   input wire logic [amp_fault_pkg::UPPER_W-1:0] clip_upper, // threshold 19:14
   input wire logic clock_error, // clock monitor level
   input wire logic [amp_fault_pkg::CUR_W-1:0] current_mag, // output current
   input wire logic dc_error, // dc offset detector level
   input wire logic overtemp, // die temperature detector level
   input wire logic sample_valid, // input sample strobe
   input wire amp_fault_pkg::stereo_sample_type sample_in, // input samples
   output logic clipped_valid, // output sample strobe
   output var amp_fault_pkg::stereo_sample_type clipped_out, // clipped samples
   output logic amp_run // amplifier allowed to run
);
   import amp_fault_pkg::*;

   if (DEV_ADDR[6:3] == 4'h0 || DEV_ADDR[6:3] == 4'hf) begin : g_addr_chk
      $error("device address falls in a reserved address group");
   end
   if (OC_NOMINAL < 12'h004) begin : g_oc_chk
      $error("nominal overcurrent level too small to scale");
   end

   ////////////////////////////////////////////////////////////////////////
   logic rst_meta_b;
   logic rst_sync_b;
   state_type s_reg;
   state_type s_next;
   logic scl_rise;
   logic scl_fall;
   logic start_cond;
   logic stop_cond;
   logic shut;
   logic oc_trip;
   logic wr_en;
   logic [7:0] fault_read;
   logic [CLIP_W-1:0] clip_level;

   function automatic logic [CUR_W-1:0] oc_limit(input logic [1:0] sel);
      unique case (sel)
         THR_100: oc_limit = OC_NOMINAL;
         THR_75: oc_limit = OC_NOMINAL - (OC_NOMINAL >> 2);
         THR_50: oc_limit = OC_NOMINAL >> 1;
         THR_25: oc_limit = OC_NOMINAL >> 2;
      endcase
   endfunction

   // saturate magnitude so both polarities stay inside the threshold
   function automatic logic signed [SAMPLE_W-1:0] clip_sample(
      input logic signed [SAMPLE_W-1:0] smp,
      input logic [CLIP_W-1:0] th);
      logic signed [SAMPLE_W-1:0] lim;
      lim = {{(SAMPLE_W-CLIP_W){1'b0}}, th};
      if (smp > lim) begin
         clip_sample = lim;
      end else if (smp < -lim) begin
         clip_sample = -lim;
      end else begin
         clip_sample = smp;
      end
   endfunction

   function automatic logic [7:0] reg_read(input logic [7:0] addr,
      input logic [7:0] fault, input logic [7:0] mid, input logic [7:0] low);
      if (addr == REG_FAULT) begin
         reg_read = fault;
      end else if (addr == REG_CLIP_MID) begin
         reg_read = mid;
      end else if (addr == REG_CLIP_LOW) begin
         reg_read = low;
      end else begin
         reg_read = 8'h00;
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_meta_b <= 1'b0;
         rst_sync_b <= 1'b0;
      end else begin
         rst_meta_b <= 1'b1;
         rst_sync_b <= rst_meta_b;
      end
   end

   assign scl_rise = s_reg.scl_s2 & ~s_reg.scl_d;
   assign scl_fall = ~s_reg.scl_s2 & s_reg.scl_d;
   assign start_cond = s_reg.scl_s2 & s_reg.scl_d & s_reg.sda_d & ~s_reg.sda_s2;
   assign stop_cond = s_reg.scl_s2 & s_reg.scl_d & ~s_reg.sda_d & s_reg.sda_s2;
   assign shut = ~s_reg.sd_s2 | ~sw_shutdown_n;
   assign oc_trip = current_mag > oc_limit(s_reg.thr_sel);
   assign wr_en = (s_reg.bus_state == BUS_WDATA) && scl_fall && !start_cond
      && !stop_cond && s_reg.bit_cnt == BYTE_BITS && !s_reg.first;
   assign clip_level = {clip_upper, s_reg.clip_mid,
      s_reg.clip_low[CLIP_LOW_MSB:CLIP_LOW_LSB]};

   always_comb begin
      fault_read = 8'h00;
      fault_read[RSVD_MSB:RSVD_LSB] = 2'h0;
      fault_read[OC_SEL_MSB:OC_SEL_LSB] = s_reg.thr_sel;
      fault_read[CLK_FLAG_BIT] = s_reg.clk_flag;
      fault_read[OC_FLAG_BIT] = s_reg.oc_flag;
      fault_read[DC_FLAG_BIT] = s_reg.dc_flag;
      fault_read[OT_FLAG_BIT] = s_reg.ot_flag;
   end

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      logic [7:0] rd;
      rd = 8'h00;
      s_next = s_reg;
      s_next.scl_s1 = scl_in;
      s_next.scl_s2 = s_reg.scl_s1;
      s_next.scl_d = s_reg.scl_s2;
      s_next.sda_s1 = sda_in;
      s_next.sda_s2 = s_reg.sda_s1;
      s_next.sda_d = s_reg.sda_s2;
      s_next.sd_s1 = amp_shutdown_n;
      s_next.sd_s2 = s_reg.sd_s1;
      s_next.sda_out = 1'b0;
      // start and stop override any byte in progress
      if (start_cond) begin
         s_next.bus_state = BUS_ADDR;
         s_next.bit_cnt = 4'h0;
         s_next.sda_oe = 1'b0;
      end else if (stop_cond) begin
         s_next.bus_state = BUS_IDLE;
         s_next.sda_oe = 1'b0;
      end else begin
         unique case (s_reg.bus_state)
            BUS_IDLE: begin
               s_next.sda_oe = 1'b0;
            end
            BUS_ADDR: begin
               if (scl_rise) begin
                  s_next.shift = {s_reg.shift[6:0], s_reg.sda_s2};
                  s_next.bit_cnt = s_reg.bit_cnt + 4'h1;
               end else if (scl_fall && s_reg.bit_cnt == BYTE_BITS) begin
                  if (s_reg.shift[7:1] == DEV_ADDR) begin
                     s_next.rw = s_reg.shift[0];
                     s_next.sda_oe = 1'b1;
                     s_next.bus_state = BUS_AACK;
                  end else begin
                     s_next.bus_state = BUS_IDLE;
                  end
               end
            end
            BUS_AACK: begin
               if (scl_fall) begin
                  s_next.bit_cnt = 4'h0;
                  if (s_reg.rw) begin
                     rd = reg_read(s_reg.ptr, fault_read, s_reg.clip_mid,
                        s_reg.clip_low);
                     s_next.shift = {rd[6:0], 1'b0};
                     s_next.sda_oe = ~rd[7];
                     s_next.bus_state = BUS_RDATA;
                  end else begin
                     s_next.sda_oe = 1'b0;
                     s_next.first = 1'b1;
                     s_next.bus_state = BUS_WDATA;
                  end
               end
            end
            BUS_WDATA: begin
               if (scl_rise) begin
                  s_next.shift = {s_reg.shift[6:0], s_reg.sda_s2};
                  s_next.bit_cnt = s_reg.bit_cnt + 4'h1;
               end else if (scl_fall && s_reg.bit_cnt == BYTE_BITS) begin
                  s_next.sda_oe = 1'b1;
                  s_next.bit_cnt = 4'h0;
                  s_next.bus_state = BUS_WACK;
                  s_next.first = 1'b0;
                  // first data byte is the register pointer
                  s_next.ptr = s_reg.first ? s_reg.shift : s_reg.ptr + 8'h01;
               end
            end
            BUS_WACK: begin
               if (scl_fall) begin
                  s_next.sda_oe = 1'b0;
                  s_next.bus_state = BUS_WDATA;
               end
            end
            BUS_RDATA: begin
               if (scl_rise) begin
                  s_next.bit_cnt = s_reg.bit_cnt + 4'h1;
               end else if (scl_fall) begin
                  if (s_reg.bit_cnt == BYTE_BITS) begin
                     s_next.sda_oe = 1'b0;
                     s_next.bus_state = BUS_RACK;
                  end else begin
                     s_next.sda_oe = ~s_reg.shift[7];
                     s_next.shift = {s_reg.shift[6:0], 1'b0};
                  end
               end
            end
            BUS_RACK: begin
               if (scl_rise) begin
                  if (s_reg.sda_s2) begin
                     s_next.bus_state = BUS_IDLE;
                  end else begin
                     s_next.ptr = s_reg.ptr + 8'h01;
                  end
               end else if (scl_fall) begin
                  rd = reg_read(s_reg.ptr, fault_read, s_reg.clip_mid,
                     s_reg.clip_low);
                  s_next.shift = {rd[6:0], 1'b0};
                  s_next.sda_oe = ~rd[7];
                  s_next.bit_cnt = 4'h0;
                  s_next.bus_state = BUS_RDATA;
               end
            end
            default: begin
               s_next.bus_state = BUS_IDLE;
               s_next.sda_oe = 1'b0;
            end
         endcase
      end
      // flags are read-only: a fault register write lands on the select only
      if (wr_en) begin
         if (s_reg.ptr == REG_FAULT) begin
            s_next.thr_sel = s_reg.shift[OC_SEL_MSB:OC_SEL_LSB];
         end else if (s_reg.ptr == REG_CLIP_MID) begin
            s_next.clip_mid = s_reg.shift;
         end else if (s_reg.ptr == REG_CLIP_LOW) begin
            s_next.clip_low = s_reg.shift;
         end
      end
      s_next.clk_flag = clock_error;
      // set beats clear so a fault during shutdown is not lost
      s_next.oc_flag = oc_trip | (s_reg.oc_flag & ~shut);
      s_next.dc_flag = dc_error | (s_reg.dc_flag & ~shut);
      s_next.ot_flag = overtemp | (s_reg.ot_flag & ~shut);
      s_next.amp_run = ~shut & ~s_reg.clk_flag & ~s_reg.oc_flag
         & ~s_reg.dc_flag & ~s_reg.ot_flag;
      s_next.out_valid = sample_valid;
      if (sample_valid) begin
         if (s_reg.amp_run) begin
            s_next.out.left = clip_sample(sample_in.left, clip_level);
            s_next.out.right = clip_sample(sample_in.right, clip_level);
         end else begin
            s_next.out = '0;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         s_reg <= STATE_RESET;
      end else begin
         s_reg <= s_next;
      end
   end

   assign sda_out = s_reg.sda_out;
   assign sda_oe = s_reg.sda_oe;
   assign amp_run = s_reg.amp_run;
   assign clipped_valid = s_reg.out_valid;
   assign clipped_out = s_reg.out;

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_sync_b);

   AST_THR_RESET: assert property ($rose(rst_sync_b) |->
      s_reg.thr_sel == THR_SEL_RESET)
      else $error("overcurrent select not at reset value");
   AST_CLK_FOLLOW: assert property (clock_error |=>
      fault_read[CLK_FLAG_BIT] ##1 !amp_run)
      else $error("clock fault flag or halt missing");
   AST_OC_LATCH: assert property ((oc_trip && !shut) |=>
      s_reg.oc_flag ##1 (s_reg.oc_flag || $past(shut)))
      else $error("overcurrent flag did not latch");
   AST_DC_HALT: assert property (dc_error |=>
      s_reg.dc_flag ##1 !amp_run)
      else $error("dc offset fault did not halt");
   AST_OT_HOLD: assert property ((s_reg.ot_flag && !shut) |=>
      s_reg.ot_flag)
      else $error("overtemp flag dropped without shutdown");
   // checks the bits actually shifted out, not the read mux
   AST_RSVD_ZERO: assert property (s_reg.ptr == REG_FAULT &&
      $rose(s_reg.bus_state == BUS_RDATA) |-> s_reg.sda_oe &&
      !s_reg.shift[7])
      else $error("reserved fault bits not zero");
   AST_CLIP_CAT: assert property (wr_en && s_reg.ptr == REG_CLIP_MID |=>
      clip_level[13:6] == $past(s_reg.shift))
      else $error("middle clip bits not placed at 13:6");
   AST_LOW_CAT: assert property (wr_en && s_reg.ptr == REG_CLIP_LOW |=>
      clip_level[5:0] == $past(s_reg.shift[7:2]))
      else $error("low clip bits not placed at 5:0");
   AST_CLEAR: assert property (shut && !oc_trip && !dc_error &&
      !overtemp |=> !s_reg.oc_flag && !s_reg.dc_flag && !s_reg.ot_flag)
      else $error("shutdown did not clear latched faults");
   AST_RO_WRITE: assert property ((wr_en && s_reg.ptr == REG_FAULT &&
      s_reg.oc_flag && !shut) |=> s_reg.oc_flag)
      else $error("write disturbed a read-only flag");
   AST_SATURATE: assert property (clipped_valid |->
      clipped_out.left <= $signed({4'h0, $past(clip_level)}) &&
      clipped_out.left >= -$signed({4'h0, $past(clip_level)}))
      else $error("sample exceeds clip threshold");

   COV_WRITE_MID: cover property (wr_en && s_reg.ptr == REG_CLIP_MID);
   COV_READ_BYTE: cover property (s_reg.bus_state == BUS_RACK && scl_rise);
   COV_OC_CLEAR: cover property (s_reg.oc_flag ##[1:20] !s_reg.oc_flag);
   COV_CLIPPED: cover property (sample_valid && s_reg.amp_run &&
      sample_in.left > $signed({4'h0, clip_level}));
endmodule
`default_nettype wire

// ---- verification/host_master.sv ----
// two-wire control port host model for the fault/clip register slice
`default_nettype none
module host_master #(
   parameter logic [6:0] DEV_ADDR = 7'h6c
) (
   input wire logic clk, // bench clock
   output logic scl, // control port clock, idles high
   output logic sda_low, // high = host pulls the data line low
   input wire logic sda_line // resolved data line level
);
   timeunit 1ns;
   timeprecision 1ps;
   logic last_ack;
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
      last_ack = 1'b0;
   end
   task automatic w(input int n);
      repeat (n) @(negedge clk);
   endtask
   ////////////////////////////////////////
   // also serves as repeated start: scl is low on entry there
   task automatic start_c();
      sda_low = 1'b0;
      w(5);
      scl = 1'b1;
      w(10);
      sda_low = 1'b1;
      w(10);
      scl = 1'b0;
      w(5);
   endtask
   task automatic stop_c();
      sda_low = 1'b1;
      w(5);
      scl = 1'b1;
      w(10);
      sda_low = 1'b0;
      w(10);
   endtask
   // margins well above the 8 clk phase and 4 clk setup/hold minimums
   task automatic bit_c(input logic b, output logic seen);
      sda_low = ~b;
      w(5);
      scl = 1'b1;
      w(5);
      seen = sda_line;
      w(5);
      scl = 1'b0;
      w(5);
   endtask
   // ninth slot always released: device acks, host nacks here; read_pair acks on its own
   task automatic byte_c(input logic [7:0] tx, output logic [7:0] rx);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_c(tx[i], s);
         rx[i] = s;
      end
      bit_c(1'b1, s);
      last_ack = ~s;
   endtask
   ////////////////////////////////////////
   task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] r;
      start_c();
      byte_c({DEV_ADDR, 1'b0}, r);
      byte_c(a, r);
      byte_c(d, r);
      stop_c();
   endtask
   task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
      logic [7:0] r;
      start_c();
      byte_c({DEV_ADDR, 1'b0}, r);
      byte_c(a, r);
      start_c();
      byte_c({DEV_ADDR, 1'b1}, r);
      byte_c(8'hff, d);
      stop_c();
   endtask
   // one transaction, pointer advances after the first data byte
   task automatic write_pair(input logic [7:0] a, input logic [7:0] d0,
      input logic [7:0] d1);
      logic [7:0] r;
      start_c();
      byte_c({DEV_ADDR, 1'b0}, r);
      byte_c(a, r);
      byte_c(d0, r);
      byte_c(d1, r);
      stop_c();
   endtask
   // host acks the first byte so the device moves on to the next one
   task automatic read_pair(input logic [7:0] a, output logic [7:0] d0,
      output logic [7:0] d1);
      logic [7:0] r;
      logic s;
      start_c();
      byte_c({DEV_ADDR, 1'b0}, r);
      byte_c(a, r);
      start_c();
      byte_c({DEV_ADDR, 1'b1}, r);
      for (int i = 7; i >= 0; i--) begin
         bit_c(1'b1, s);
         d0[i] = s;
      end
      bit_c(1'b0, s);
      byte_c(8'hff, d1);
      stop_c();
   endtask
   task automatic probe(input logic [6:0] ad);
      logic [7:0] r;
      start_c();
      byte_c({ad, 1'b0}, r);
      stop_c();
   endtask
endmodule
`default_nettype wire

// ---- verification/testbench.sv ----
// self-checking bench for the fault status and clip threshold registers
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import amp_fault_pkg::*;
   localparam logic [11:0] NOM = 12'h800;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic scl, host_low, sda_oe, sda_line, s_valid, c_valid, run;
   logic shut_pin_n, shut_sw_n, clk_err, dc_err, hot;
   logic [5:0] upper;
   logic [11:0] cur, lim;
   stereo_sample_type s_in, c_out;
   logic [7:0] rd;
   logic [7:0] rd2;
   logic sda_drv;
   logic [7:0] rsv [4] = '{REG_RSVD_A, REG_RSVD_LO, 8'h0c, REG_RSVD_HI};
   int err_total = 0;
   int n_checks = 0;
   always #4 clk = ~clk;
   // pull-up on the data line; either party may pull it low
   assign sda_line = ~((sda_oe & ~sda_drv) | host_low);
   amp_fault_status_clip_regs #(.OC_NOMINAL(NOM)) i_dut (
      .clk(clk), .rst_b(rst_b), .scl_in(scl), .sda_in(sda_line),
      .sda_out(sda_drv), .sda_oe(sda_oe), .amp_shutdown_n(shut_pin_n),
      .sw_shutdown_n(shut_sw_n), .clip_upper(upper), .clock_error(clk_err),
      .current_mag(cur), .dc_error(dc_err), .overtemp(hot),
      .sample_valid(s_valid), .sample_in(s_in), .clipped_valid(c_valid),
      .clipped_out(c_out), .amp_run(run));
   host_master i_host (.clk(clk), .scl(scl), .sda_low(host_low),
      .sda_line(sda_line));
   ////////////////////////////////////////
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic check(input logic [47:0] seen, input logic [47:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic rcheck(input logic [7:0] a, input logic [7:0] exp);
      i_host.read_reg(a, rd);
      check({40'h0, rd}, {40'h0, exp});
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // one-cycle detector pulse; flag must outlive it
   task automatic trip(input int b, input logic [11:0] c);
      cur = (b == 2) ? c : 12'h000;
      dc_err = (b == 1);
      hot = (b == 0);
      cyc(1);
      cur = 12'h000;
      dc_err = 1'b0;
      hot = 1'b0;
      cyc(3);
   endtask
   task automatic toggle_shut(input logic use_sw);
      {shut_sw_n, shut_pin_n} = use_sw ? 2'b01 : 2'b10;
      cyc(8);
      {shut_sw_n, shut_pin_n} = 2'b11;
      cyc(8);
   endtask
   task automatic sample(input logic [23:0] l, r, el, er);
      s_in = '{left: l, right: r};
      s_valid = 1'b1;
      cyc(1);
      s_valid = 1'b0;
      check(c_valid, 1'b1);
      check(c_out, {el, er});
   endtask
   ////////////////////////////////////////
   initial begin
      {shut_pin_n, shut_sw_n, clk_err, dc_err, hot, s_valid} = 6'h10;
      upper = 6'h00;
      cur = 12'h000;
      s_in = '0;
      cyc(3);
      rst_b = 1'b1;
      shut_pin_n = 1'b1;
      cyc(10);
      check(run, 1'b1);
      rcheck(REG_FAULT, 8'h00);
      rcheck(REG_CLIP_MID, CLIP_MID_RESET);
      rcheck(REG_CLIP_LOW, CLIP_LOW_RESET);
      i_host.write_reg(REG_FAULT, 8'h3f);
      rcheck(REG_FAULT, 8'h30);
      for (int s = 0; s < 4; s++) begin
         lim = NOM - 12'(s) * (NOM >> 2);
         i_host.write_reg(REG_FAULT, {2'b00, s[1:0], 4'h0});
         cur = lim;
         cyc(4);
         check(run, 1'b1);
         trip(2, lim + 12'h001);
         check(run, 1'b0);
         i_host.write_reg(REG_FAULT, {2'b00, s[1:0], 4'h0});
         rcheck(REG_FAULT, {2'b00, s[1:0], 4'h4});
         toggle_shut(s[0]);
         rcheck(REG_FAULT, {2'b00, s[1:0], 4'h0});
         check(run, 1'b1);
      end
      for (int b = 0; b < 2; b++) begin
         trip(b, 12'h000);
         rcheck(REG_FAULT, 8'h30 | (8'h01 << b));
         check(run, 1'b0);
         toggle_shut(b[0]);
         rcheck(REG_FAULT, 8'h30);
      end
      clk_err = 1'b1;
      cyc(2);
      rcheck(REG_FAULT, 8'h38);
      clk_err = 1'b0;
      cyc(2);
      rcheck(REG_FAULT, 8'h30);
      foreach (rsv[i]) begin
         i_host.write_reg(rsv[i], 8'ha5);
         rcheck(rsv[i], 8'h00);
      end
      rcheck(REG_FAULT, 8'h30);
      i_host.write_reg(REG_CLIP_MID, 8'h01);
      i_host.write_reg(REG_CLIP_LOW, 8'h80);
      rcheck(REG_CLIP_MID, 8'h01);
      rcheck(REG_CLIP_LOW, 8'h80);
      // threshold {00_0000, 0000_0001, 10_0000} = 0x00060
      sample(24'h000100, 24'hffff00, 24'h000060, 24'hffffa0);
      sample(24'h000060, 24'hffffa0, 24'h000060, 24'hffffa0);
      sample(24'h000010, 24'hfffff0, 24'h000010, 24'hfffff0);
      upper = 6'h01;
      // threshold with bit 14 from the upper field = 0x04060
      sample(24'h7fffff, 24'h800000, 24'h004060, 24'hffbfa0);
      shut_sw_n = 1'b0;
      cyc(4);
      sample(24'h000010, 24'hfffff0, 24'h000000, 24'h000000);
      shut_sw_n = 1'b1;
      i_host.write_pair(REG_CLIP_MID, 8'h02, 8'h40);
      i_host.read_pair(REG_CLIP_MID, rd, rd2);
      check({40'h0, rd}, {40'h0, 8'h02});
      check({40'h0, rd2}, {40'h0, 8'h40});
      i_host.probe(7'h6d);
      check(i_host.last_ack, 1'b0);
      i_host.probe(7'h6c);
      check(i_host.last_ack, 1'b1);
      print_verdict();
   end
   // about 31k cycles expected; cut off at 90k, nearly three times that
   initial begin
      #(90000 * 8);
      err_total++;
      $display("MISMATCH t=%0t watchdog expired", $time);
      print_verdict();
   end
endmodule
`default_nettype wire
